// ==== logic/pnp_pkg.sv ====
// constants and types for the parallel programming port
package pnp_pkg;
  // command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;
  // action selector codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  // {extended, low/high} selector codes for fuse and lock access
  localparam logic [1:0] SEL_FUSE_LO  = 2'h0;
  localparam logic [1:0] SEL_FUSE_HI  = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] RD_FUSE_HI   = 2'h3;
  localparam logic [1:0] RD_FUSE_EXT  = 2'h2;
  localparam logic [1:0] RD_LOCK      = 2'h1;
  // memory geometry
  localparam int FLASH_WORDS      = 4096;
  localparam int FLASH_PAGE_WORDS = 32;
  localparam int EE_BYTES         = 256;
  localparam int EE_PAGE_BYTES    = 4;
  // reset values: erased fuses and lock bits read as ones
  localparam logic [7:0] FUSE_RESET    = 8'hFF;
  localparam logic [7:0] LOCK_RESET    = 8'hFF;
  localparam logic [7:0] LOCK_BOTH     = 8'h03;
  localparam logic [7:0] SIG_ADDR_MAX  = 8'h02;
  localparam logic [7:0] CAL_ADDR      = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS  = 4000;
  localparam int CNT_W         = 16;

  typedef enum logic {PNP_READY, PNP_BUSY} pnp_mode_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  addr_lo;
    logic [7:0]  addr_hi;
    logic [7:0]  data_lo;
    logic [7:0]  data_hi;
    logic        load_q;
    logic        page_latch_strobe_q;
    logic        wr_q;
    pnp_mode_t   mode;
    logic [CNT_W-1:0] cnt;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [7:0]  fuse_ext;
    logic [7:0]  lock;
    logic [EE_PAGE_BYTES-1:0] ee_mask;
    logic [7:0]  dout;
    logic        doe;
    logic        rdy;
  } pnp_state_t;
endpackage : pnp_pkg

// ==== logic/pnp_port.sv ====
// parallel programming port: command, address and data latches, memories, fuses, lock bits
module pnp_port #(
  parameter int         PROG_TIME_NS = pnp_pkg::PROG_TIME_NS,
  parameter logic [7:0] SIG_BYTE0    = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG_BYTE1    = 8'hA5, // arbitrary value
  parameter logic [7:0] SIG_BYTE2    = 8'h3C, // arbitrary value
  parameter logic [7:0] CAL_BYTE     = 8'h80
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_action_select_hi,
  input  wire logic       i_action_select_lo,
  input  wire logic       i_low_high_byte_select,
  input  wire logic       i_extended_byte_select,
  input  wire logic       i_load_strobe,
  input  wire logic       i_page_latch_strobe,
  input  wire logic       i_wr_n,
  input  wire logic       i_oe_n,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_ready_busy
);
  localparam int FW  = $clog2(pnp_pkg::FLASH_WORDS);
  localparam int PW  = $clog2(pnp_pkg::FLASH_PAGE_WORDS);
  localparam int EW  = $clog2(pnp_pkg::EE_BYTES);
  localparam int EPW = $clog2(pnp_pkg::EE_PAGE_BYTES);
  localparam int PROG_CYC_I = (PROG_TIME_NS + pnp_pkg::CLK_PERIOD_NS - 1)
                              / pnp_pkg::CLK_PERIOD_NS;
  localparam logic [pnp_pkg::CNT_W-1:0] PROG_CYC =
    pnp_pkg::CNT_W'((PROG_CYC_I < 1) ? 1 : PROG_CYC_I);

  pnp_pkg::pnp_state_t st;
  pnp_pkg::pnp_state_t next_st;

  // memories: no reset, contents are the array's own
  logic [15:0] flash_mem [pnp_pkg::FLASH_WORDS];
  logic [7:0]  ee_mem    [pnp_pkg::EE_BYTES];
  logic [15:0] page_buf  [pnp_pkg::FLASH_PAGE_WORDS];
  logic [7:0]  ee_buf    [pnp_pkg::EE_PAGE_BYTES];

  logic [1:0]    act;
  logic [1:0]    sel;
  logic          load_rise;
  logic          page_latch_strobe_rise;
  logic          wr_fall;
  logic          latch_flash;
  logic          latch_ee;
  logic          go_flash;
  logic          go_ee;
  logic          go_any;
  logic [FW-1:0] faddr;
  logic [PW-1:0] fword;
  logic [FW-PW-1:0] fpage;
  logic [EPW-1:0]   eword;
  logic [EW-EPW-1:0] epage;
  logic          lock_refused;

  // strobe edges; inputs are synchronous so the level itself is sampled
  assign act        = {i_action_select_hi, i_action_select_lo};
  assign sel        = {i_extended_byte_select, i_low_high_byte_select};
  assign load_rise  = i_load_strobe & ~st.load_q;
  assign page_latch_strobe_rise = i_page_latch_strobe & ~st.page_latch_strobe_q;
  // write strobes during busy are ignored, the programmer must wait for ready
  assign wr_fall    = ~i_wr_n & st.wr_q & (st.mode == pnp_pkg::PNP_READY);

  // address split: the top of the low byte joins the page number
  assign faddr = FW'({st.addr_hi, st.addr_lo});
  assign fword = faddr[PW-1:0];
  assign fpage = faddr[FW-1:PW];
  assign eword = st.addr_lo[EPW-1:0];
  assign epage = st.addr_lo[EW-1:EPW];

  assign latch_flash = page_latch_strobe_rise & i_low_high_byte_select
                       & (st.cmd == pnp_pkg::CMD_WR_FLASH);
  assign latch_ee    = page_latch_strobe_rise & (st.cmd == pnp_pkg::CMD_WR_EE);
  assign go_flash    = wr_fall & (st.cmd == pnp_pkg::CMD_WR_FLASH);
  assign go_ee       = wr_fall & ~i_low_high_byte_select
                       & (st.cmd == pnp_pkg::CMD_WR_EE);
  assign go_any      = go_flash | go_ee | (wr_fall & ((st.cmd == pnp_pkg::CMD_WR_FUSE)
                       | (st.cmd == pnp_pkg::CMD_WR_LOCK)));
  // once both lock bits are programmed, no further lock programming
  assign lock_refused = (st.lock & pnp_pkg::LOCK_BOTH) == 8'h00;

  // next state: latches, programming sequencer, read mux
  always_comb begin
    next_st         = st;
    next_st.load_q  = i_load_strobe;
    next_st.page_latch_strobe_q = i_page_latch_strobe;
    next_st.wr_q    = i_wr_n;
    // latches hold until reloaded, so one command serves many accesses
    if (load_rise) begin
      case (act)
        pnp_pkg::ACT_ADDR: begin
          if (i_low_high_byte_select) begin
            next_st.addr_hi = i_data;
          end else begin
            next_st.addr_lo = i_data;
          end
        end
        pnp_pkg::ACT_DATA: begin
          if (i_low_high_byte_select) begin
            next_st.data_hi = i_data;
          end else begin
            next_st.data_lo = i_data;
          end
        end
        pnp_pkg::ACT_CMD: begin
          if (!i_low_high_byte_select) begin
            next_st.cmd = i_data;
            if (i_data == pnp_pkg::CMD_NOP) begin
              next_st.ee_mask = '0;
            end
          end
        end
        default: begin
          // idle action: nothing is loaded
        end
      endcase
    end
    if (latch_ee) begin
      next_st.ee_mask[eword] = 1'b1;
    end
    // programming sequencer
    case (st.mode)
      pnp_pkg::PNP_READY: begin
        if (go_any) begin
          next_st.mode = pnp_pkg::PNP_BUSY;
          next_st.cnt  = PROG_CYC;
          if (go_ee) begin
            next_st.ee_mask = '0;
          end
          if (st.cmd == pnp_pkg::CMD_WR_FUSE) begin
            // data byte is stored as is: 0 programmed, 1 erased
            case (sel)
              pnp_pkg::SEL_FUSE_LO:  next_st.fuse_lo  = st.data_lo;
              pnp_pkg::SEL_FUSE_HI:  next_st.fuse_hi  = st.data_lo;
              pnp_pkg::SEL_FUSE_EXT: next_st.fuse_ext = st.data_lo;
              default: begin
              end
            endcase
          end
          // and-in only: a lock bit can never go back to one here
          if ((st.cmd == pnp_pkg::CMD_WR_LOCK) && !lock_refused) begin
            next_st.lock = st.lock & st.data_lo;
          end
        end
      end
      pnp_pkg::PNP_BUSY: begin
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt <= 1) begin
          next_st.mode = pnp_pkg::PNP_READY;
        end
      end
      default: begin
        next_st.mode = pnp_pkg::PNP_READY;
      end
    endcase
    next_st.rdy = (next_st.mode == pnp_pkg::PNP_READY);
    // read mux; the bus is released whenever output enable is high
    next_st.doe  = ~i_oe_n;
    next_st.dout = 8'h00;
    if (!i_oe_n) begin
      case (st.cmd)
        pnp_pkg::CMD_RD_FLASH: begin
          next_st.dout = i_low_high_byte_select ? flash_mem[faddr][15:8]
                                                : flash_mem[faddr][7:0];
        end
        pnp_pkg::CMD_RD_EE: begin
          next_st.dout = ee_mem[st.addr_lo];
        end
        pnp_pkg::CMD_RD_FUSE: begin
          case (sel)
            pnp_pkg::SEL_FUSE_LO: next_st.dout = st.fuse_lo;
            pnp_pkg::RD_FUSE_HI:  next_st.dout = st.fuse_hi;
            pnp_pkg::RD_FUSE_EXT: next_st.dout = st.fuse_ext;
            default:              next_st.dout = st.lock;
          endcase
        end
        pnp_pkg::CMD_RD_SIG: begin
          if (i_low_high_byte_select) begin
            if (st.addr_lo == pnp_pkg::CAL_ADDR) begin
              next_st.dout = CAL_BYTE;
            end
          end else begin
            case (st.addr_lo)
              8'h00:   next_st.dout = SIG_BYTE0;
              8'h01:   next_st.dout = SIG_BYTE1;
              8'h02:   next_st.dout = SIG_BYTE2;
              default: next_st.dout = 8'h00;
            endcase
          end
        end
        default: begin
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st          <= '0;
      st.load_q   <= 1'b0;
      st.wr_q     <= 1'b1;
      st.mode     <= pnp_pkg::PNP_READY;
      st.fuse_lo  <= pnp_pkg::FUSE_RESET;
      st.fuse_hi  <= pnp_pkg::FUSE_RESET;
      st.fuse_ext <= pnp_pkg::FUSE_RESET;
      st.lock     <= pnp_pkg::LOCK_RESET;
      st.rdy      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // page buffers and arrays; the whole flash page is written at the write strobe
  always_ff @(posedge i_ref_clk) begin
    if (latch_flash) begin
      page_buf[fword] <= {st.data_hi, st.data_lo};
    end
    if (latch_ee) begin
      ee_buf[eword] <= st.data_lo;
    end
    if (go_flash) begin
      for (int i = 0; i < pnp_pkg::FLASH_PAGE_WORDS; i++) begin
        flash_mem[{fpage, PW'(i)}] <= page_buf[i];
      end
    end
    // only bytes latched since the last page write or no operation command are altered
    if (go_ee) begin
      for (int j = 0; j < pnp_pkg::EE_PAGE_BYTES; j++) begin
        if (st.ee_mask[j]) begin
          ee_mem[{epage, EPW'(j)}] <= ee_buf[j];
        end
      end
    end
  end

  assign o_data       = st.dout;
  assign o_data_oe    = st.doe;
  assign o_ready_busy = st.rdy;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_cmd_load;
    load_rise && act == pnp_pkg::ACT_CMD && !i_low_high_byte_select;
  endsequence
  sequence s_busy_run;
    !o_ready_busy [*8];
  endsequence

  a_cmd_load: assert property (s_cmd_load |=> st.cmd == $past(i_data))
    else $error("command byte not loaded");
  a_nop_clear: assert property (s_cmd_load ##0 i_data == 8'h00 |=> st.ee_mask == '0)
    else $error("no operation did not clear write state");
  // the byte selector is taken at the strobe edge, the programmer may move it later
  a_addr_load: assert property (load_rise && act == pnp_pkg::ACT_ADDR
      |=> ($past(i_low_high_byte_select) ? st.addr_hi : st.addr_lo) == $past(i_data))
    else $error("address byte not loaded");
  a_data_load: assert property (load_rise && act == pnp_pkg::ACT_DATA
      |=> ($past(i_low_high_byte_select) ? st.data_hi : st.data_lo) == $past(i_data))
    else $error("data byte not loaded");
  a_idle_hold: assert property (load_rise && act == 2'h3
      |=> $stable(st.cmd) && $stable(st.addr_lo) && $stable(st.data_lo))
    else $error("idle action changed a latch");
  a_busy_seq: assert property (go_any |=> s_busy_run ##[1:300] o_ready_busy)
    else $error("busy period wrong");
  a_bus_drive: assert property (o_data_oe == $past(!i_oe_n)
      && (o_data_oe || o_data == 8'h00))
    else $error("bus driven without output enable");
  a_lock_keep: assert property ((st.lock & ~$past(st.lock)) == 8'h00)
    else $error("lock bit returned to unprogrammed");
  a_lock_refuse: assert property (lock_refused |=> $stable(st.lock))
    else $error("lock programming not refused");
  a_sig_read: assert property (!i_oe_n && !i_low_high_byte_select
      && st.cmd == pnp_pkg::CMD_RD_SIG && st.addr_lo == 8'h01
      |=> o_data == SIG_BYTE1)
    else $error("signature byte wrong");

  // sequencer: load the count, release at its end, refuse strobes while busy
  a_busy_load: assert property (go_any |=> st.cnt == PROG_CYC && !o_ready_busy)
    else $error("busy count not loaded");
  a_busy_end: assert property (!o_ready_busy && st.cnt == 1 |=> o_ready_busy)
    else $error("ready not restored at end of count");
  a_ready_idle: assert property (o_ready_busy && !go_any |=> o_ready_busy)
    else $error("busy without a write strobe");
  a_busy_refuse: assert property (!o_ready_busy |-> !go_any)
    else $error("write accepted while busy");

  // fuse writes: the selectors pick the byte, the data low byte lands as is
  sequence s_fuse_go;
    go_any && st.cmd == pnp_pkg::CMD_WR_FUSE;
  endsequence
  a_fuse_lo: assert property (s_fuse_go ##0 sel == pnp_pkg::SEL_FUSE_LO
      |=> st.fuse_lo == $past(st.data_lo))
    else $error("low fuse byte not written");
  a_fuse_hi: assert property (s_fuse_go ##0 sel == pnp_pkg::SEL_FUSE_HI
      |=> st.fuse_hi == $past(st.data_lo))
    else $error("high fuse byte not written");
  a_fuse_ext: assert property (s_fuse_go ##0 sel == pnp_pkg::SEL_FUSE_EXT
      |=> st.fuse_ext == $past(st.data_lo))
    else $error("extended fuse byte not written");
  a_lock_prog: assert property (go_any && st.cmd == pnp_pkg::CMD_WR_LOCK
      && !lock_refused |=> st.lock == $past(st.lock & st.data_lo))
    else $error("lock bits not programmed");

  // reads of lock bits and calibration byte
  a_lock_read: assert property (!i_oe_n && st.cmd == pnp_pkg::CMD_RD_FUSE
      && sel == pnp_pkg::RD_LOCK |=> o_data == $past(st.lock))
    else $error("lock bits not presented");
  a_cal_read: assert property (!i_oe_n && i_low_high_byte_select
      && st.cmd == pnp_pkg::CMD_RD_SIG && st.addr_lo == pnp_pkg::CAL_ADDR
      |=> o_data == CAL_BYTE)
    else $error("calibration byte wrong");

  // latches move only on a load strobe rise; eeprom marks follow latch and write
  a_cmd_hold: assert property (!load_rise
      |=> $stable(st.cmd) && $stable(st.addr_lo) && $stable(st.addr_hi))
    else $error("latch changed without a load");
  a_ee_mark: assert property (latch_ee && !go_ee |=> st.ee_mask[$past(eword)])
    else $error("eeprom byte not marked");
  a_ee_clear: assert property (go_ee |=> st.ee_mask == '0)
    else $error("eeprom marks not cleared by page write");
endmodule : pnp_port

// ==== tb/pnp_programmer.sv ====
// programmer model: drives strobes, selectors and the shared data bus
module pnp_programmer (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe,
  input  wire logic       i_ready_busy,
  output logic            o_act_hi,
  output logic            o_act_lo,
  output logic            o_bs1,
  output logic            o_bs2,
  output logic            o_load,
  output logic            o_page_latch_strobe,
  output logic            o_wr_n,
  output logic            o_oe_n,
  output logic      [7:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv;
  // released bus shows the inverse of our last value, never a stale copy
  assign o_bus = i_dev_oe ? i_dev_data : (o_oe_n ? drv : ~drv);
  // idle levels at time zero
  initial begin
    {o_act_hi, o_act_lo, o_bs1, o_bs2, o_load, o_page_latch_strobe} = '0;
    {o_wr_n, o_oe_n} = 2'h3;
    drv = 8'h00;
  end
  // step off the edge so the design samples settled levels
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #5;
  endtask : cyc
  // load pulse, each strobe level held a full cycle
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
    {o_act_hi, o_act_lo} = act;
    o_bs1 = bs1;
    drv = d;
    o_load = 1'b1;
    cyc(1);
    o_load = 1'b0;
    cyc(1);
  endtask : load
  // page latch pulse
  task automatic latch(input logic bs1);
    o_bs1 = bs1;
    o_page_latch_strobe = 1'b1;
    cyc(1);
    o_page_latch_strobe = 1'b0;
    cyc(1);
  endtask : latch
  // write pulse, then count busy cycles; -1 when ready never returns
  task automatic write(input logic bs2, input logic bs1, output int n);
    {o_bs2, o_bs1} = {bs2, bs1};
    o_wr_n = 1'b0;
    cyc(1);
    o_wr_n = 1'b1;
    n = 0;
    while (i_ready_busy !== 1'b1 && n < 200) begin
      n++;
      cyc(1);
    end
    if (n == 200) n = -1;
  endtask : write
  // one read with output enable low; returns {bus enable, byte}
  task automatic read(input logic bs2, input logic bs1, output logic [8:0] r);
    {o_bs2, o_bs1} = {bs2, bs1};
    o_oe_n = 1'b0;
    cyc(1);
    r = {i_dev_oe, i_dev_data};
    o_oe_n = 1'b1;
    cyc(2);
  endtask : read
endmodule : pnp_programmer

// ==== tb/pnp_port_test.sv ====
// self-checking bench for the parallel programming port
module pnp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  // short programming time keeps the run brief
  localparam int         PROG_NS = 500;
  localparam int         BUSY    = PROG_NS / pnp_pkg::CLK_PERIOD_NS;
  localparam logic [7:0] SIG [3] = '{8'h11, 8'h22, 8'h33}; // arbitrary values
  localparam logic [7:0] CAL     = 8'h44;
  localparam logic [7:0] FV  [3] = '{8'hA5, 8'h5A, 8'hF0};
  localparam logic [1:0] WS  [3] = '{2'h0, 2'h1, 2'h2};
  localparam logic [1:0] RS  [3] = '{2'h0, 2'h3, 2'h2};
  localparam logic [7:0] LD  [4] = '{8'hFE, 8'hFF, 8'hFC, 8'hF8};
  localparam logic [7:0] LE  [4] = '{8'hFE, 8'hFE, 8'hFC, 8'hFC};
  logic       i_ref_clk;
  logic       i_rstn;
  wire logic  ah, al, bs1, bs2, ld_s, pg, wr_n, oe_n, doe, rdy;
  wire logic  [7:0] bus, dout;
  int         num_errors = 0;
  int         n_tests = 0;
  int         n;
  logic [8:0] r;

  pnp_port #(.PROG_TIME_NS(PROG_NS), .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]),
             .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) u_pnp_port (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_action_select_hi(ah),
    .i_action_select_lo(al), .i_low_high_byte_select(bs1), .i_extended_byte_select(bs2),
    .i_load_strobe(ld_s), .i_page_latch_strobe(pg), .i_wr_n(wr_n), .i_oe_n(oe_n),
    .i_data(bus), .o_data(dout), .o_data_oe(doe), .o_ready_busy(rdy));
  pnp_programmer u_pnp_programmer (
    .i_ref_clk(i_ref_clk), .i_dev_data(dout), .i_dev_oe(doe), .i_ready_busy(rdy),
    .o_act_hi(ah), .o_act_lo(al), .o_bs1(bs1), .o_bs2(bs2), .o_load(ld_s),
    .o_page_latch_strobe(pg), .o_wr_n(wr_n), .o_oe_n(oe_n), .o_bus(bus));

  // 20 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkn(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkn
  task automatic ld(input logic [1:0] act, input logic b1, input logic [7:0] d);
    u_pnp_programmer.load(act, b1, d);
  endtask : ld
  task automatic cmd(input logic [7:0] c);
    u_pnp_programmer.load(pnp_pkg::ACT_CMD, 1'b0, c);
  endtask : cmd
  // a read also proves the bus is driven only while enabled
  task automatic rd(input string what, input logic b2, input logic b1, input logic [7:0] e);
    u_pnp_programmer.read(b2, b1, r);
    chk(what, e, r[7:0]);
    chk({what, " drive"}, 8'h01, {7'h00, r[8]});
    chk({what, " release"}, 8'h00, {7'h00, doe});
  endtask : rd
  // a hung write ends the run at once
  task automatic wr(input string what, input logic b1, input int exp);
    u_pnp_programmer.write(1'b0, b1, n);
    if (n < 0) begin
      num_errors++;
      $display("ERROR %s expected %0d seen timeout", what, exp);
      tally_and_finish();
    end else begin
      chkn(what, exp, n);
    end
  endtask : wr

  initial begin
    i_rstn = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    #5;
    i_rstn = 1'b1;
    chk("ready after reset", 8'h01, {7'h00, rdy});
    chk("bus after reset", 8'h00, {7'h00, doe});
    // flash: two words of page 9, words 5 and 6
    cmd(pnp_pkg::CMD_WR_FLASH);
    ld(pnp_pkg::ACT_ADDR, 1'b1, 8'h01);
    for (int w = 5; w < 7; w++) begin
      ld(pnp_pkg::ACT_ADDR, 1'b0, 8'(8'h20 + w));
      ld(pnp_pkg::ACT_DATA, 1'b0, 8'(w));
      ld(pnp_pkg::ACT_DATA, 1'b1, 8'(8'hC0 + w));
      u_pnp_programmer.latch(1'b1);
    end
    wr("flash busy", 1'b0, BUSY);
    cmd(pnp_pkg::CMD_NOP);
    wr("write after nop", 1'b0, 0);
    cmd(pnp_pkg::CMD_RD_FLASH);
    for (int w = 5; w < 7; w++) begin
      ld(pnp_pkg::ACT_ADDR, 1'b0, 8'(8'h20 + w));
      rd("flash low", 1'b0, 1'b0, 8'(w));
      rd("flash high", 1'b0, 1'b1, 8'(8'hC0 + w));
    end
    $display("test flash done");
    // eeprom page write of one byte
    cmd(pnp_pkg::CMD_WR_EE);
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h09);
    ld(pnp_pkg::ACT_DATA, 1'b0, 8'h3C);
    u_pnp_programmer.latch(1'b0);
    wr("eeprom busy", 1'b0, BUSY);
    cmd(pnp_pkg::CMD_RD_EE);
    rd("eeprom byte", 1'b0, 1'b0, 8'h3C);
    $display("test eeprom done");
    // each fuse byte written and read back through its own selectors
    for (int i = 0; i < 3; i++) begin
      cmd(pnp_pkg::CMD_WR_FUSE);
      ld(pnp_pkg::ACT_DATA, 1'b0, FV[i]);
      u_pnp_programmer.write(WS[i][1], WS[i][0], n);
      chkn("fuse busy", BUSY, n);
      cmd(pnp_pkg::CMD_RD_FUSE);
      rd("fuse byte", RS[i][1], RS[i][0], FV[i]);
    end
    $display("test fuses done");
    // lock bits: program, try to erase, program both, then a refused write
    rd("lock reset", 1'b0, 1'b1, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      cmd(pnp_pkg::CMD_WR_LOCK);
      ld(pnp_pkg::ACT_DATA, 1'b0, LD[i]);
      wr("lock busy", 1'b0, BUSY);
      cmd(pnp_pkg::CMD_RD_FUSE);
      rd("lock bits", 1'b0, 1'b1, LE[i]);
    end
    $display("test lock done");
    // identification and calibration bytes
    cmd(pnp_pkg::CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      ld(pnp_pkg::ACT_ADDR, 1'b0, 8'(i));
      rd("signature", 1'b0, 1'b0, SIG[i]);
    end
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h00);
    rd("calibration", 1'b0, 1'b1, CAL);
    // idle action and a command load with high byte select change nothing
    ld(2'h3, 1'b0, 8'h02);
    ld(pnp_pkg::ACT_CMD, 1'b1, pnp_pkg::CMD_NOP);
    rd("after idle load", 1'b0, 1'b0, SIG[0]);
    $display("test identification done");
    tally_and_finish();
  end
endmodule : pnp_port_test
